// ### dfs_top.sv
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// RQ1: Resolver fault lights drive-fault and resolver lamps, drops drive-ok, sets bit B.
// RQ2: Resolver fault latches at power-up or while running.
// RQ3: Any latched module fault except current integral overload inhibits torque on every axis.
// RQ4: Resettable fault clears only on reset pulse with its cause gone.
// RQ5: Motor overtemp lights lamps, drops drive-ok and motor-ok, sets bit C.
// RQ6: Motor overtemp indication follows temperature; torque inhibit stays latched.
// RQ7: Phase short lights short lamp, drops drive-ok, sets bit D.
// RQ8: Phase short ignores reset inputs; only power cycle clears it.
// RQ9: Incoherent phase currents drop drive-ok, light drive fault, set bit E.
// RQ10: Auxiliary or HV-referred rail fault drops drive-ok, sets bit N.
// RQ11: Missing card drops drive-ok, lights drive fault, sets L, inhibits torque.
// RQ12: Reset within 5 s of save raises memory error, bit L, message, inhibit.
// RQ13: Memory error clears only by a new save command or power cycle, not by reset.
// RQ14: Bus fault lights power and fault lamps, drops drive-ok, sets M.
// RQ15: Heatsink trip lights its lamp, drops drive-ok, sets O; power cycle clears.
// RQ16: Current integral overload sets G, lamp, limits current to rated setting.
// RQ17: Current limiting releases itself; bit G stays until reset pulse.
// RQ18: Watchdog fault lights fault and watchdog lamps, drops drive-ok, inhibits.
// RQ19: Speed error over limit sets F, drops drive-ok, inhibits that axis only.
// RQ20: Reset button and remote reset are synchronised to one pulse each.
// RQ21: Drive-ok is the inverse of the OR of its latched faults, with motor overtemp taken from its live level.
module dfs_top #(
	parameter int unsigned SAVE_WINDOW_CYC = dfs_pkg::SAVE_WINDOW_CYC
) (
	input  wire logic                                    CLK,
	input  wire logic                                    NRST,
	input  wire logic [2:0]                              AVS_ADDRESS,
	input  wire logic                                    AVS_READ,
	input  wire logic                                    AVS_WRITE,
	input  wire logic [31:0]                             AVS_WRITEDATA,
	input  wire logic [3:0]                              AVS_BYTEENABLE,
	output logic      [31:0]                             AVS_READDATA,
	output logic                                         AVS_WAITREQUEST,
	input  wire logic                                    RESOLVER_BAD,
	input  wire logic                                    MOTOR_HOT,
	input  wire logic                                    PHASE_SHORTED,
	input  wire logic                                    PHASE_INCOHERENT,
	input  wire logic                                    AUX_RAIL_BAD,
	input  wire logic                                    HV_AUX_RAIL_BAD,
	input  wire logic                                    CARD_ABSENT,
	input  wire logic                                    BUS_BAD,
	input  wire logic                                    HEATSINK_TRIP,
	input  wire logic                                    IT_OVER,
	input  wire logic                                    WATCHDOG_FAIL,
	input  wire logic [dfs_pkg::AXES*dfs_pkg::SPD_W-1:0] SPEED_ERROR,
	input  wire logic                                    RESET_BUTTON,
	input  wire logic                                    REMOTE_FAULT_CLEAR,
	output logic                                         DRIVE_FAULT_LAMP,
	output logic                                         RESOLVER_FAULT_LAMP,
	output logic                                         MOTOR_OVERTEMP_LAMP,
	output logic                                         PHASE_SHORT_LAMP,
	output logic                                         WATCHDOG_LAMP,
	output logic                                         HEATSINK_OVERTEMP_LAMP,
	output logic                                         POWER_OK_LAMP,
	output logic                                         DRIVE_OK,
	output logic                                         MOTOR_OK,
	output logic                                         NVM_ERROR_MESSAGE,
	output logic      [dfs_pkg::AXES-1:0]                TORQUE_INHIBIT,
	output logic      [dfs_pkg::CUR_W-1:0]               CURRENT_LIMIT,
	output logic      [15:0]                             FAULT_STATUS_STRING
);
	logic                         rst_s1;
	logic                         rst_n;
	logic                         btn_pulse;
	logic                         rem_pulse;
	logic                         clr;
	logic                         save_cmd;
	logic                         save_active;
	logic [dfs_pkg::NFAULT-1:0]   cause;
	logic [dfs_pkg::NFAULT-1:0]   latched;
	logic [dfs_pkg::AXES-1:0]     ovs_cause;
	logic [dfs_pkg::AXES-1:0]     ovs_lat;
	logic                         nvm_err;
	logic                         module_inh;
	logic                         dok_fault;
	logic [15:0]                  next_fss;
	logic [dfs_pkg::CUR_W-1:0]    cur_limit;
	logic [dfs_pkg::CUR_W-1:0]    rated_current_cmd;
	logic [dfs_pkg::SPD_W-1:0]    speed_error_limit_cmd;
	logic [4:0]                   byte_addr;
	logic                         access;
	logic [31:0]                  next_rdata;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Reset release through two flops
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	dfs_pulse_sync u_btn (
		.clk   (CLK),
		.rst_n (rst_n),
		.din   (RESET_BUTTON),
		.pulse (btn_pulse)
	);

	dfs_pulse_sync u_rem (
		.clk   (CLK),
		.rst_n (rst_n),
		.din   (REMOTE_FAULT_CLEAR),
		.pulse (rem_pulse)
	);

	assign clr = btn_pulse | rem_pulse; // RQ4 RQ20

	dfs_save_timer #(
		.WINDOW_CYC (SAVE_WINDOW_CYC)
	) u_save (
		.clk    (CLK),
		.rst_n  (rst_n),
		.start  (save_cmd),
		.active (save_active)
	);

	// Avalon-MM slave: one wait cycle, then the transfer completes
	assign byte_addr = {AVS_ADDRESS, 2'b00};
	assign access    = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
	assign save_cmd  = access & AVS_WRITE & (byte_addr == dfs_pkg::OFS_SAVE);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			AVS_WAITREQUEST <= 1'b1;
		end else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	always_comb begin
		next_rdata = 32'h0;
		if (byte_addr == dfs_pkg::OFS_STATUS) begin
			next_rdata = {16'h0, FAULT_STATUS_STRING};
		end else if (byte_addr == dfs_pkg::OFS_LIVE) begin
			next_rdata = {15'h0, module_inh, 5'h0, cause};
		end else if (byte_addr == dfs_pkg::OFS_CUR_LIMIT) begin
			next_rdata = {16'h0, cur_limit};
		end else if (byte_addr == dfs_pkg::OFS_RATED_CUR) begin
			next_rdata = {16'h0, rated_current_cmd};
		end else if (byte_addr == dfs_pkg::OFS_SPEED_LIM) begin
			next_rdata = {16'h0, speed_error_limit_cmd};
		end else if (byte_addr == dfs_pkg::OFS_SAVE) begin
			next_rdata[dfs_pkg::SAVE_NVM_BIT] = nvm_err;
			next_rdata[dfs_pkg::SAVE_WIN_BIT] = save_active;
		end
	end

	// Read data prepared in the wait cycle, valid when waitrequest drops
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			AVS_READDATA <= 32'h0;
		end else if (AVS_READ & AVS_WAITREQUEST) begin
			AVS_READDATA <= next_rdata;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			cur_limit             <= dfs_pkg::RST_CUR_LIMIT;
			rated_current_cmd     <= dfs_pkg::RST_RATED_CUR;
			speed_error_limit_cmd <= dfs_pkg::RST_SPEED_LIM;
		end else if (access & AVS_WRITE) begin
			if (byte_addr == dfs_pkg::OFS_CUR_LIMIT) begin
				cur_limit <= merge16(cur_limit, AVS_WRITEDATA, AVS_BYTEENABLE);
			end else if (byte_addr == dfs_pkg::OFS_RATED_CUR) begin
				rated_current_cmd <= merge16(rated_current_cmd, AVS_WRITEDATA,
					AVS_BYTEENABLE);
			end else if (byte_addr == dfs_pkg::OFS_SPEED_LIM) begin
				speed_error_limit_cmd <= merge16(speed_error_limit_cmd, AVS_WRITEDATA,
					AVS_BYTEENABLE);
			end
		end
	end

	// Fault causes; bus and HV rail hysteresis is in the analog comparators
	always_comb begin
		cause = '0;
		cause[dfs_pkg::F_RES]   = RESOLVER_BAD; // RQ2
		cause[dfs_pkg::F_MOT]   = MOTOR_HOT;
		cause[dfs_pkg::F_SHORT] = PHASE_SHORTED;
		cause[dfs_pkg::F_COH]   = PHASE_INCOHERENT;
		cause[dfs_pkg::F_AUX]   = AUX_RAIL_BAD;
		cause[dfs_pkg::F_HVAUX] = HV_AUX_RAIL_BAD;
		cause[dfs_pkg::F_CARD]  = CARD_ABSENT;
		cause[dfs_pkg::F_BUS]   = BUS_BAD;
		cause[dfs_pkg::F_HEAT]  = HEATSINK_TRIP;
		cause[dfs_pkg::F_IT]    = IT_OVER;
		cause[dfs_pkg::F_WDT]   = WATCHDOG_FAIL;
	end

	always_comb begin
		for (int a = 0; a < dfs_pkg::AXES; a++) begin
			ovs_cause[a] = SPEED_ERROR[a*dfs_pkg::SPD_W +: dfs_pkg::SPD_W]
				> speed_error_limit_cmd;
		end
	end

	// A present cause always wins over a reset pulse
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			latched <= '0;
		end else begin
			latched <= cause | (latched & ~({dfs_pkg::NFAULT{clr}}
				& dfs_pkg::CLEARABLE_MASK)); // RQ2 RQ4 RQ8 RQ15
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ovs_lat <= '0;
		end else begin
			ovs_lat <= ovs_cause | (ovs_lat & ~{dfs_pkg::AXES{clr}}); // RQ19
		end
	end

	// Early reset after a save corrupts the memory; only a new save or a power cycle recovers
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			nvm_err <= 1'b0;
		end else if (clr & save_active) begin
			nvm_err <= 1'b1; // RQ12
		end else if (save_cmd) begin
			nvm_err <= 1'b0; // RQ13
		end
	end

	assign module_inh = |(latched & dfs_pkg::INHIBIT_MASK) | nvm_err; // RQ3 RQ11 RQ18
	assign dok_fault  = |(latched & dfs_pkg::DRIVE_OK_MASK) | cause[dfs_pkg::F_MOT]
		| nvm_err | (|ovs_lat); // RQ21

	always_comb begin
		next_fss = 16'h0;
		next_fss[dfs_pkg::FSS_B] = latched[dfs_pkg::F_RES]; // RQ1
		next_fss[dfs_pkg::FSS_C] = latched[dfs_pkg::F_MOT]; // RQ5
		next_fss[dfs_pkg::FSS_D] = latched[dfs_pkg::F_SHORT]; // RQ7
		next_fss[dfs_pkg::FSS_E] = latched[dfs_pkg::F_COH]; // RQ9
		next_fss[dfs_pkg::FSS_F] = |ovs_lat; // RQ19
		next_fss[dfs_pkg::FSS_G] = latched[dfs_pkg::F_IT]; // RQ16 RQ17
		next_fss[dfs_pkg::FSS_L] = latched[dfs_pkg::F_CARD] | nvm_err; // RQ11 RQ12
		next_fss[dfs_pkg::FSS_M] = latched[dfs_pkg::F_BUS]; // RQ14
		next_fss[dfs_pkg::FSS_N] = latched[dfs_pkg::F_AUX] | latched[dfs_pkg::F_HVAUX]; // RQ10
		next_fss[dfs_pkg::FSS_O] = latched[dfs_pkg::F_HEAT]; // RQ15
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			FAULT_STATUS_STRING <= 16'h0;
			DRIVE_OK            <= 1'b0;
			TORQUE_INHIBIT      <= '1;
			CURRENT_LIMIT       <= dfs_pkg::RST_CUR_LIMIT;
		end else begin
			FAULT_STATUS_STRING <= next_fss;
			DRIVE_OK            <= ~dok_fault; // RQ21
			TORQUE_INHIBIT      <= {dfs_pkg::AXES{module_inh}} | ovs_lat; // RQ3 RQ19
			// Overload limiting tracks the live integral, not the latch
			CURRENT_LIMIT       <= cause[dfs_pkg::F_IT] ? rated_current_cmd
				: cur_limit; // RQ16 RQ17
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			DRIVE_FAULT_LAMP       <= 1'b0;
			RESOLVER_FAULT_LAMP    <= 1'b0;
			MOTOR_OVERTEMP_LAMP    <= 1'b0;
			PHASE_SHORT_LAMP       <= 1'b0;
			WATCHDOG_LAMP          <= 1'b0;
			HEATSINK_OVERTEMP_LAMP <= 1'b0;
			POWER_OK_LAMP          <= 1'b0;
			MOTOR_OK               <= 1'b1;
			NVM_ERROR_MESSAGE      <= 1'b0;
		end else begin
			DRIVE_FAULT_LAMP       <= |(latched & ~(11'h1 << dfs_pkg::F_MOT))
				| cause[dfs_pkg::F_MOT] | nvm_err | (|ovs_lat);
			RESOLVER_FAULT_LAMP    <= latched[dfs_pkg::F_RES]; // RQ1
			MOTOR_OVERTEMP_LAMP    <= cause[dfs_pkg::F_MOT]; // RQ5 RQ6
			PHASE_SHORT_LAMP       <= latched[dfs_pkg::F_SHORT]; // RQ7
			WATCHDOG_LAMP          <= latched[dfs_pkg::F_WDT]; // RQ18
			HEATSINK_OVERTEMP_LAMP <= latched[dfs_pkg::F_HEAT]; // RQ15
			POWER_OK_LAMP          <= latched[dfs_pkg::F_BUS]; // RQ14
			MOTOR_OK               <= ~cause[dfs_pkg::F_MOT]; // RQ5 RQ6
			NVM_ERROR_MESSAGE      <= nvm_err; // RQ12
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n);

	AST_RES_IND: assert property (cause[dfs_pkg::F_RES] |-> ##2
		(RESOLVER_FAULT_LAMP && DRIVE_FAULT_LAMP && !DRIVE_OK
		&& FAULT_STATUS_STRING[dfs_pkg::FSS_B])) else $error("resolver not indicated"); // RQ1
	AST_RES_LATCH: assert property (cause[dfs_pkg::F_RES] |=>
		latched[dfs_pkg::F_RES]) else $error("resolver fault not latched"); // RQ2
	AST_ALL_AXES: assert property (module_inh |=> TORQUE_INHIBIT == '1)
		else $error("module fault left an axis enabled"); // RQ3
	AST_CLEAR_COND: assert property ($fell(latched[dfs_pkg::F_COH]) |->
		$past(clr) && !$past(cause[dfs_pkg::F_COH])) else $error("fault cleared wrongly"); // RQ4
	AST_MOT_IND: assert property (cause[dfs_pkg::F_MOT] |=>
		(!MOTOR_OK && !DRIVE_OK && MOTOR_OVERTEMP_LAMP)
		##1 FAULT_STATUS_STRING[dfs_pkg::FSS_C]) else $error("motor temp not indicated"); // RQ5
	AST_MOT_FOLLOW: assert property ((!cause[dfs_pkg::F_MOT])[*2] |=>
		MOTOR_OK && !MOTOR_OVERTEMP_LAMP) else $error("motor-ok did not recover"); // RQ6
	AST_MOT_INH: assert property (latched[dfs_pkg::F_MOT] && !clr |=>
		module_inh) else $error("motor temp inhibit released without reset"); // RQ6
	AST_SHORT_HOLD: assert property (latched[dfs_pkg::F_SHORT] |=>
		latched[dfs_pkg::F_SHORT] && PHASE_SHORT_LAMP) else $error("phase short cleared"); // RQ8
	AST_SHORT_IND: assert property (cause[dfs_pkg::F_SHORT] |-> ##2
		(!DRIVE_OK && FAULT_STATUS_STRING[dfs_pkg::FSS_D])) else $error("short not shown"); // RQ7
	AST_COH_IND: assert property (cause[dfs_pkg::F_COH] |-> ##2
		(!DRIVE_OK && FAULT_STATUS_STRING[dfs_pkg::FSS_E])) else $error("coherence not shown"); // RQ9
	AST_AUX_IND: assert property (cause[dfs_pkg::F_HVAUX] |-> ##2
		(!DRIVE_OK && FAULT_STATUS_STRING[dfs_pkg::FSS_N])) else $error("rail not shown"); // RQ10
	AST_CARD_IND: assert property (cause[dfs_pkg::F_CARD] |-> ##2
		(TORQUE_INHIBIT == '1 && FAULT_STATUS_STRING[dfs_pkg::FSS_L])) else $error("card"); // RQ11
	AST_NVM_SET: assert property (clr && save_active |=> nvm_err ##1
		NVM_ERROR_MESSAGE) else $error("early reset after save not flagged"); // RQ12
	AST_NVM_HOLD: assert property (nvm_err && !save_cmd |=> nvm_err)
		else $error("memory error cleared without save"); // RQ13
	AST_BUS_IND: assert property (cause[dfs_pkg::F_BUS] |-> ##2
		(POWER_OK_LAMP && FAULT_STATUS_STRING[dfs_pkg::FSS_M])) else $error("bus fault"); // RQ14
	AST_HEAT_HOLD: assert property (latched[dfs_pkg::F_HEAT] |=>
		latched[dfs_pkg::F_HEAT]) else $error("heatsink fault cleared"); // RQ15
	AST_IT_LIMIT: assert property (cause[dfs_pkg::F_IT] |=>
		CURRENT_LIMIT == $past(rated_current_cmd)) else $error("overload limit wrong"); // RQ16
	AST_IT_FREE: assert property (!cause[dfs_pkg::F_IT] |=>
		CURRENT_LIMIT == $past(cur_limit)) else $error("limit not released"); // RQ17
	AST_WDT_IND: assert property (cause[dfs_pkg::F_WDT] |-> ##2
		(WATCHDOG_LAMP && !DRIVE_OK && TORQUE_INHIBIT == '1)) else $error("watchdog"); // RQ18
	AST_OVS_AXIS: assert property (ovs_lat[0] && !module_inh && !ovs_lat[1] |=>
		TORQUE_INHIBIT[0] && !TORQUE_INHIBIT[1]) else $error("overspeed axis wrong"); // RQ19
	AST_DOK: assert property ($past(rst_n) |-> DRIVE_OK == !$past(dok_fault))
		else $error("drive-ok mismatch"); // RQ21

	COV_RES_CLEAR: cover property (latched[dfs_pkg::F_RES] ##1 !latched[dfs_pkg::F_RES]);
	COV_NVM: cover property (clr && save_active);
	COV_IT_LIMIT: cover property (cause[dfs_pkg::F_IT] ##1 !cause[dfs_pkg::F_IT]);
	COV_OVS: cover property (ovs_lat != '0 && !module_inh);
endmodule

// ### dfs_pkg.sv
package dfs_pkg;
	// Timing
	localparam int unsigned CLK_HZ         = 40_000_000;
	localparam int unsigned SAVE_WINDOW_MS = 5000;
	localparam int unsigned SAVE_WINDOW_CYC = SAVE_WINDOW_MS * (CLK_HZ / 1000);

	// Geometry
	localparam int AXES   = 3;
	localparam int NFAULT = 11;
	localparam int CUR_W  = 16;
	localparam int SPD_W  = 16;

	// Register byte offsets
	localparam logic [4:0] OFS_STATUS    = 5'h00;
	localparam logic [4:0] OFS_LIVE      = 5'h04;
	localparam logic [4:0] OFS_CUR_LIMIT = 5'h08;
	localparam logic [4:0] OFS_RATED_CUR = 5'h0c;
	localparam logic [4:0] OFS_SPEED_LIM = 5'h10;
	localparam logic [4:0] OFS_SAVE      = 5'h14;

	// Reset values
	localparam logic [CUR_W-1:0] RST_CUR_LIMIT = 16'hffff;
	localparam logic [CUR_W-1:0] RST_RATED_CUR = 16'h8000;
	localparam logic [SPD_W-1:0] RST_SPEED_LIM = 16'h1000;

	// Fault index in the cause and latch vectors
	localparam int F_RES   = 0;
	localparam int F_MOT   = 1;
	localparam int F_SHORT = 2;
	localparam int F_COH   = 3;
	localparam int F_AUX   = 4;
	localparam int F_HVAUX = 5;
	localparam int F_CARD  = 6;
	localparam int F_BUS   = 7;
	localparam int F_HEAT  = 8;
	localparam int F_IT    = 9;
	localparam int F_WDT   = 10;

	// Faults a reset pulse may clear (not phase short, not heatsink)
	localparam logic [NFAULT-1:0] CLEARABLE_MASK = 11'h6fb;
	// Faults that inhibit torque on every axis (all but current integral)
	localparam logic [NFAULT-1:0] INHIBIT_MASK   = 11'h5ff;
	// Latched faults that drop drive-ok (motor temp uses its live level)
	localparam logic [NFAULT-1:0] DRIVE_OK_MASK  = 11'h5fd;

	// Fault status string bit positions, letter minus A
	localparam int FSS_B = 1;
	localparam int FSS_C = 2;
	localparam int FSS_D = 3;
	localparam int FSS_E = 4;
	localparam int FSS_F = 5;
	localparam int FSS_G = 6;
	localparam int FSS_L = 11;
	localparam int FSS_M = 12;
	localparam int FSS_N = 13;
	localparam int FSS_O = 14;

	// Save register read fields
	localparam int SAVE_NVM_BIT = 0;
	localparam int SAVE_WIN_BIT = 1;
	// Live register: inhibit flag above the causes
	localparam int LIVE_INH_BIT = 16;
endpackage

// ### dfs_pulse_sync.sv
`timescale 1ns/1ps
module dfs_pulse_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      pulse
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// One clean pulse per rising edge, held level gives no repeat
	assign pulse = s2 & ~s3; // RQ20

	AST_ONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		pulse |=> !pulse) else $error("reset request pulse longer than one cycle"); // RQ20
endmodule

// ### dfs_save_timer.sv
`timescale 1ns/1ps
module dfs_save_timer #(
	parameter int unsigned WINDOW_CYC = dfs_pkg::SAVE_WINDOW_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      active
);
	logic [31:0] remaining;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remaining <= 32'h0;
		end else if (start) begin
			remaining <= WINDOW_CYC[31:0];
		end else if (remaining != 32'h0) begin
			remaining <= remaining - 32'h1;
		end
	end

	assign active = (remaining != 32'h0);

	AST_WINDOW_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
		start |=> active && remaining == WINDOW_CYC[31:0]) else $error("save window not armed"); // RQ12
endmodule

// ### dfs_field_model.sv
`timescale 1ns/1ps
module dfs_field_model (
	input  wire logic        clk,
	input  wire logic [10:0] cause_req,
	input  wire logic        press_btn,
	input  wire logic        press_rem,
	output logic      [10:0] cause,
	output logic             btn,
	output logic             rem
);
	logic [2:0] btn_cnt = 3'h0;
	logic [2:0] rem_cnt = 3'h0;

	// Detector levels change only on the clock, as a synchronous source would
	always_ff @(posedge clk) begin
		cause <= cause_req;
	end

	// A press lasts several cycles so the synchroniser must collapse it to one pulse
	always_ff @(posedge clk) begin
		btn_cnt <= press_btn ? 3'h4 : ((btn_cnt != 3'h0) ? btn_cnt - 3'h1 : 3'h0);
		rem_cnt <= press_rem ? 3'h4 : ((rem_cnt != 3'h0) ? rem_cnt - 3'h1 : 3'h0);
	end

	assign btn = (btn_cnt != 3'h0);
	assign rem = (rem_cnt != 3'h0);
endmodule

// ### dfs_top_tb.sv
`timescale 1ns/1ps
module dfs_top_tb;
	localparam int unsigned WIN = 50;
	localparam int IDX [9] = '{0, 1, 3, 4, 5, 6, 7, 9, 10};
	localparam logic [15:0] STR [9] = '{16'h0002, 16'h0004, 16'h0010, 16'h2000, 16'h2000,
		16'h0800, 16'h1000, 16'h0040, 16'h0000};
	// Lamps, then drive-ok, then motor-ok
	localparam logic [8:0] LOK [9] = '{9'h181, 9'h140, 9'h101, 9'h101, 9'h101, 9'h101,
		9'h105, 9'h103, 9'h111};
	localparam logic [15:0] RV [3] = '{16'hffff, 16'h8000, 16'h1000};

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  adr = 3'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic [10:0] cause_req = 11'h000;
	logic [10:0] cause;
	logic        btn;
	logic        rem;
	logic        press_btn = 1'b0;
	logic        press_rem = 1'b0;
	logic [47:0] spd = 48'h0;
	logic [6:0]  lamps;
	logic        dok;
	logic        mok;
	logic        nvm;
	logic [2:0]  inh;
	logic [15:0] ilim;
	logic [15:0] fss;
	logic [31:0] d;
	int          fail_count = 0;
	int          n_compared = 0;

	always #12.5 clk = ~clk;

	dfs_field_model u_dfs_field_model (.clk(clk), .cause_req(cause_req), .press_btn(press_btn),
		.press_rem(press_rem), .cause(cause), .btn(btn), .rem(rem));

	dfs_top #(.SAVE_WINDOW_CYC(WIN)) u_dfs_top (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .RESOLVER_BAD(cause[0]),
		.MOTOR_HOT(cause[1]), .PHASE_SHORTED(cause[2]), .PHASE_INCOHERENT(cause[3]),
		.AUX_RAIL_BAD(cause[4]), .HV_AUX_RAIL_BAD(cause[5]), .CARD_ABSENT(cause[6]),
		.BUS_BAD(cause[7]), .HEATSINK_TRIP(cause[8]), .IT_OVER(cause[9]),
		.WATCHDOG_FAIL(cause[10]), .SPEED_ERROR(spd), .RESET_BUTTON(btn),
		.REMOTE_FAULT_CLEAR(rem), .DRIVE_FAULT_LAMP(lamps[6]), .RESOLVER_FAULT_LAMP(lamps[5]),
		.MOTOR_OVERTEMP_LAMP(lamps[4]), .PHASE_SHORT_LAMP(lamps[3]), .WATCHDOG_LAMP(lamps[2]),
		.HEATSINK_OVERTEMP_LAMP(lamps[1]), .POWER_OK_LAMP(lamps[0]), .DRIVE_OK(dok),
		.MOTOR_OK(mok), .NVM_ERROR_MESSAGE(nvm), .TORQUE_INHIBIT(inh), .CURRENT_LIMIT(ilim),
		.FAULT_STATUS_STRING(fss));

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Request held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] wd,
		output logic [31:0] rd_o);
		int i;
		@(posedge clk);
		adr <= a;
		wdat <= wd;
		rd <= ~w;
		wr <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		rd_o = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			fail_count++;
			end_sim();
		end
	endtask

	task automatic press(input bit remote);
		@(posedge clk);
		if (remote) press_rem <= 1'b1;
		else press_btn <= 1'b1;
		@(posedge clk);
		press_rem <= 1'b0;
		press_btn <= 1'b0;
		tick(10);
	endtask

	task automatic set_cause(input int idx, input logic v);
		@(posedge clk);
		cause_req[idx] <= v;
		tick(5);
	endtask

	task automatic power_cycle();
		@(posedge clk);
		nrst <= 1'b0;
		tick(3);
		@(posedge clk);
		nrst <= 1'b1;
		tick(4);
	endtask

	initial begin
		power_cycle();
		check("idle", {fss, inh, lamps, dok, mok}, 32'h3);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 3'(i + 2), 32'h0, d);
			check("reset value", d, {16'h0, RV[i]});
		end
		bus(1'b1, 3'h7, 32'hffff, d);
		bus(1'b0, 3'h7, 32'h0, d);
		check("unmapped", d, 32'h0);
		bus(1'b1, 3'h0, 32'hffff, d);
		bus(1'b0, 3'h0, 32'h0, d);
		check("status read-only", d, 32'h0);
		bus(1'b1, 3'h2, 32'h7777, d);
		bus(1'b1, 3'h3, 32'h1234, d);
		bus(1'b0, 3'h2, 32'h0, d);
		check("limit write", d, 32'h7777);
		$display("registers done");

		for (int k = 0; k < 9; k++) begin
			set_cause(IDX[k], 1'b1);
			check("string", fss, STR[k]);
			check("lamps and ok", {lamps, dok, mok}, LOK[k]);
			check("inhibit", inh, (k == 7) ? 3'h0 : 3'h7);
			check("limit", ilim, (k == 7) ? 16'h1234 : 16'h7777);
			bus(1'b0, 3'h1, 32'h0, d);
			check("live", d, (32'h1 << IDX[k]) | ((k == 7) ? 32'h0 : 32'h10000));
			press(k[0]);
			check("held string", fss, STR[k]);
			set_cause(IDX[k], 1'b0);
			check("after cause", fss, STR[k]);
			check("inhibit kept", inh, (k == 7) ? 3'h0 : 3'h7);
			check("limit back", ilim, 16'h7777);
			if (k == 1) check("motor lamps", {lamps, dok, mok}, 9'h003);
			press(~k[0]);
			check("cleared", {fss, inh, lamps, dok, mok}, 32'h3);
		end
		$display("clearable faults done");

		for (int k = 0; k < 2; k++) begin
			set_cause(k ? 8 : 2, 1'b1);
			check("latch", {fss, lamps, dok},
				k ? {16'h4000, 7'h42, 1'b0} : {16'h0008, 7'h48, 1'b0});
			set_cause(k ? 8 : 2, 1'b0);
			press(1'b0);
			press(1'b1);
			check("kept", {fss, inh}, {(k ? 16'h4000 : 16'h0008), 3'h7});
			power_cycle();
			check("power cycle", {fss, inh, dok}, {16'h0, 3'h0, 1'b1});
		end
		$display("power-cycle faults done");

		@(posedge clk);
		spd <= {16'h0, 16'h1000, 16'h1001};
		tick(5);
		check("overspeed", {fss, inh, dok}, {16'h0020, 3'h1, 1'b0});
		@(posedge clk);
		spd <= 48'h0;
		press(1'b1);
		check("overspeed clear", {fss, inh, dok}, {16'h0, 3'h0, 1'b1});
		$display("overspeed done");

		bus(1'b1, 3'h5, 32'h1, d);
		bus(1'b0, 3'h5, 32'h0, d);
		check("window", d, 32'h2);
		press(1'b1);
		check("memory error", {nvm, fss, inh}, {1'b1, 16'h0800, 3'h7});
		tick(WIN);
		press(1'b0);
		check("memory error kept", nvm, 1'b1);
		bus(1'b1, 3'h5, 32'h1, d);
		tick(WIN + 5);
		bus(1'b0, 3'h5, 32'h0, d);
		check("save idle", d, 32'h0);
		press(1'b0);
		check("late reset", {nvm, fss, inh}, 20'h0);
		$display("memory error done");
		end_sim();
	end
endmodule
